// [logic/agct_regs.sv]
/*
  agct_regs: global configuration and output test-pattern register bank.
  Holds the setup, burst end, phase slip, divider, output mode, ddr and
  test-pattern registers, decodes them against the three-level select pins
  and drives the effective settings and the test word.
  Assumes the serial protocol engine outside presents one-cycle read and
  write strobes with a byte address on ref_clk; select pins are asynchronous.
*/
`timescale 1ns/1ps
module agct_regs
  import agct_pkg::*;
(
  input  wire logic        ref_clk,                  // 10 MHz clock
  input  wire logic        rstn,                     // synchronous reset, active low
  input  wire logic [12:0] reg_addr,                 // register address
  input  wire logic [7:0]  reg_wdata,                // write data
  input  wire logic        reg_wr,                   // write strobe, one cycle
  input  wire logic        reg_rd,                   // read strobe, one cycle
  output logic      [7:0]  reg_rdata,                // read data, registered
  output logic             reg_rvalid,               // read data valid pulse
  input  wire logic [1:0]  divider_select_pin,       // three-level divider pin
  input  wire logic [1:0]  output_drive_select_pin,  // three-level drive pin
  input  wire logic [1:0]  output_coding_select_pin, // three-level coding pin
  output logic      [2:0]  div_ratio,                // effective one-hot divisor
  output logic             div_en,                   // divided clock enable
  output logic      [2:0]  out_drive,                // effective one-hot drive mode
  output logic      [2:0]  out_coding,               // effective one-hot coding
  output logic             ddr_enable,               // double data rate on
  output logic             dll_slow,                 // loop range slow
  output logic             serial_out_drive_on,      // serial data out active
  output logic             lsb_first,                // serial bit order lsb first
  output logic      [7:0]  burst_end,                // burst last address
  output logic      [15:0] test_word,                // test word, registered
  output logic             test_active               // test pattern on bus
);
  logic [7:0]  setup_reg, setup_next;
  logic [7:0]  burst_reg, burst_next;
  logic [7:0]  slip_reg, slip_next;
  logic [7:0]  divider_select_pin_reg, divider_select_pin_next;
  logic [7:0]  fmt_reg, fmt_next;
  logic [7:0]  ddr_reg, ddr_next;
  logic [7:0]  patt_reg, patt_next;
  logic [15:0] word1_reg, word1_next;
  logic [15:0] word2_reg, word2_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg;
  logic        slip_pulse;
  logic        soft_rst;
  logic [7:0]  status_val;
  logic [5:0]  pin_meta_reg;
  logic [5:0]  pin_sync_reg;
  logic [1:0]  div_pin, drv_pin, cod_pin;

  // two-stage synchronisers for the three-level pins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_meta_reg <= {RST_BYTE[5:0]};
      pin_sync_reg <= {RST_BYTE[5:0]};
    end else begin
      pin_meta_reg <= {output_coding_select_pin, output_drive_select_pin, divider_select_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign div_pin = pin_sync_reg[1:0];
  assign drv_pin = pin_sync_reg[3:2];
  assign cod_pin = pin_sync_reg[5:4];

  // map a pin level onto the one-hot select codes
  function automatic logic [2:0] pin_code(input logic [1:0] lvl);
    logic [2:0] c;
    c = SEL_ONE;
    if (lvl == PIN_MID) begin
      c = SEL_TWO;
    end else if (lvl == PIN_HIGH) begin
      c = SEL_FOUR;
    end
    return c;
  endfunction

  // a register field wins when it holds a legal nonzero code, else the pin
  function automatic logic [2:0] pick(input logic [2:0] fld, input logic [1:0] lvl);
    logic [2:0] c;
    c = pin_code(lvl);
    if (fld == SEL_ONE || fld == SEL_TWO || fld == SEL_FOUR) begin
      c = fld;
    end
    return c;
  endfunction

  // effective selections
  assign div_ratio  = pick(divider_select_pin_reg[2:0], div_pin);
  assign out_drive  = pick(fmt_reg[7:5], drv_pin);
  assign out_coding = pick(fmt_reg[2:0], cod_pin);
  assign dll_slow   = ddr_reg[DLL_SLOW_BIT];
  assign ddr_enable = ddr_reg[DDR_ENABLE_BIT];
  assign serial_out_drive_on = setup_reg[SETUP_DRIVE_ON_BIT];
  assign lsb_first  = setup_reg[SETUP_LSB_FIRST_BIT];
  assign burst_end  = burst_reg;

  // status shows loop range, ddr and whether a pattern is on the bus
  always_comb begin
    status_val = ddr_reg & DDR_SETUP_MASK;
    status_val[PATT_STAT_BIT] = test_active;
  end

  // one slip per rising edge of the stored slip bit
  assign slip_pulse = reg_wr && reg_addr == ADDR_DIVIDED_CLOCK_SLIP
                      && reg_wdata[SLIP_BIT] && !slip_reg[SLIP_BIT];
  assign soft_rst   = reg_wr && reg_addr == ADDR_SERIAL_PORT_SETUP
                      && reg_wdata[SETUP_SOFT_RST_BIT];

  // register writes, soft reset and read mux
  always_comb begin
    setup_next  = setup_reg;
    burst_next  = burst_reg;
    slip_next   = slip_reg;
    divider_select_pin_next = divider_select_pin_reg;
    fmt_next    = fmt_reg;
    ddr_next    = ddr_reg;
    patt_next   = patt_reg;
    word1_next  = word1_reg;
    word2_next  = word2_reg;
    rdata_next  = rdata_reg;
    if (soft_rst) begin
      // divider and output format kept
      setup_next = RST_BYTE;
      burst_next = RST_BYTE;
      slip_next  = RST_BYTE;
      ddr_next   = RST_BYTE;
      patt_next  = RST_BYTE;
      word1_next = RST_WORD;
      word2_next = RST_WORD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SERIAL_PORT_SETUP: begin
          // mirror bits 2:0 follow bits 5..7
          setup_next = {reg_wdata[7:5], 2'b00, reg_wdata[5], reg_wdata[6], reg_wdata[7]};
        end
        ADDR_BURST_LAST_ADDRESS:   burst_next  = reg_wdata;
        ADDR_DIVIDED_CLOCK_SLIP:   slip_next   = reg_wdata;
        ADDR_CLOCK_DIVIDER_SELECT: divider_select_pin_next = reg_wdata;
        ADDR_OUTPUT_FORMAT_SELECT: fmt_next    = reg_wdata;
        // a write toggles the held bits, so the host xor sequence lands the desired value
        ADDR_OUTPUT_DDR_SETUP:     ddr_next    = ddr_reg ^ (reg_wdata & DDR_SETUP_MASK);
        ADDR_PATTERN_MODE_CONTROL: patt_next   = reg_wdata;
        ADDR_PATTERN_ONE_LOW:      word1_next[7:0]  = reg_wdata;
        ADDR_PATTERN_ONE_HIGH:     word1_next[15:8] = reg_wdata;
        ADDR_PATTERN_TWO_LOW:      word2_next[7:0]  = reg_wdata;
        ADDR_PATTERN_TWO_HIGH:     word2_next[15:8] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SERIAL_PORT_SETUP:    rdata_next = setup_reg;
        ADDR_BURST_LAST_ADDRESS:   rdata_next = burst_reg;
        ADDR_DIVIDED_CLOCK_SLIP:   rdata_next = slip_reg;
        ADDR_CLOCK_DIVIDER_SELECT: rdata_next = divider_select_pin_reg;
        ADDR_OUTPUT_FORMAT_SELECT: rdata_next = fmt_reg;
        ADDR_OUTPUT_DDR_SETUP:     rdata_next = (ddr_reg & DDR_SETUP_MASK) ^ status_val;
        ADDR_LOOP_AND_RATE_STATUS: rdata_next = status_val;
        ADDR_PATTERN_MODE_CONTROL: rdata_next = patt_reg;
        ADDR_PATTERN_ONE_LOW:      rdata_next = word1_reg[7:0];
        ADDR_PATTERN_ONE_HIGH:     rdata_next = word1_reg[15:8];
        ADDR_PATTERN_TWO_LOW:      rdata_next = word2_reg[7:0];
        ADDR_PATTERN_TWO_HIGH:     rdata_next = word2_reg[15:8];
        default:                   rdata_next = RST_BYTE;
      endcase
    end
  end

  // register storage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      setup_reg  <= RST_BYTE;
      burst_reg  <= RST_BYTE;
      slip_reg   <= RST_BYTE;
      divider_select_pin_reg <= RST_BYTE;
      fmt_reg    <= RST_BYTE;
      ddr_reg    <= RST_BYTE;
      patt_reg   <= RST_BYTE;
      word1_reg  <= RST_WORD;
      word2_reg  <= RST_WORD;
      rdata_reg  <= RST_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      setup_reg  <= setup_next;
      burst_reg  <= burst_next;
      slip_reg   <= slip_next;
      divider_select_pin_reg <= divider_select_pin_next;
      fmt_reg    <= fmt_next;
      ddr_reg    <= ddr_next;
      patt_reg   <= patt_next;
      word1_reg  <= word1_next;
      word2_reg  <= word2_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= reg_rd;
    end
  end
  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // divided sample clock
  agct_divider u_div (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .ratio      (div_ratio),
    .slip_pulse (slip_pulse),
    .div_en     (div_en)
  );

  // test pattern generator, stepped on divided clock phases
  logic [7:0]  stage1_reg, stage1_next;
  logic [7:0]  stage2_reg, stage2_next;
  logic        phase_reg, phase_next;
  logic [15:0] word_reg, word_next;
  logic        act_reg, act_next;
  logic [15:0] w1, w2;
  logic        pair;

  // fixed and user words for the staged code
  always_comb begin
    w1   = WORD_ZEROS;
    w2   = WORD_ZEROS;
    pair = 1'b0;
    unique case (stage2_reg[3:0])
      TEST_MID:     w1 = WORD_MIDSCALE;
      TEST_POS:     w1 = WORD_ONES;
      TEST_NEG:     w1 = WORD_ZEROS;
      TEST_CHECKER: begin
        w1   = WORD_CHECK_A;
        w2   = WORD_CHECK_B;
        pair = 1'b1;
      end
      TEST_ONEZERO: begin
        w1   = WORD_ONES;
        w2   = WORD_ZEROS;
        pair = 1'b1;
      end
      TEST_USER: begin
        w1   = word1_reg;
        w2   = word2_reg;
        pair = 1'b1;
      end
      default: ;
    endcase
  end

  // staging delays the enable by two sample phases, word toggles on phases
  always_comb begin
    stage1_next = stage1_reg;
    stage2_next = stage2_reg;
    phase_next  = phase_reg;
    word_next   = word_reg;
    act_next    = act_reg;
    if (div_en) begin
      stage1_next = patt_reg;
      stage2_next = stage1_reg;
      act_next    = (w1 != WORD_ZEROS || stage2_reg[3:0] == TEST_NEG || pair)
                    && stage2_reg[3:0] != TEST_OFF;
      // reserved user mode codes behave as static
      if (stage2_reg[USER_MODE_HI:USER_MODE_LO] == USER_ALTERNATE && pair) begin
        phase_next = !phase_reg;
        word_next  = phase_reg ? w2 : w1;
      end else begin
        phase_next = 1'b0;
        word_next  = w1;
      end
    end
  end

  // pattern state
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1_reg <= RST_BYTE;
      stage2_reg <= RST_BYTE;
      phase_reg  <= 1'b0;
      word_reg   <= RST_WORD;
      act_reg    <= 1'b0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      phase_reg  <= phase_next;
      word_reg   <= word_next;
      act_reg    <= act_next;
    end
  end
  assign test_word   = word_reg;
  assign test_active = act_reg;
endmodule

// [logic/agct_pkg.sv]
/*
  agct_pkg: register offsets, field positions, reset values, codes and
  fixed test words for the global configuration and test-pattern bank.
  Assumes nothing of its surroundings; imported whole by the design modules.
*/
package agct_pkg;
  // register offsets, 13-bit serial address space
  localparam logic [12:0] ADDR_SERIAL_PORT_SETUP    = 13'h0000;
  localparam logic [12:0] ADDR_BURST_LAST_ADDRESS   = 13'h0002;
  localparam logic [12:0] ADDR_DIVIDED_CLOCK_SLIP   = 13'h0071;
  localparam logic [12:0] ADDR_CLOCK_DIVIDER_SELECT = 13'h0072;
  localparam logic [12:0] ADDR_OUTPUT_FORMAT_SELECT = 13'h0073;
  localparam logic [12:0] ADDR_OUTPUT_DDR_SETUP     = 13'h0074;
  localparam logic [12:0] ADDR_LOOP_AND_RATE_STATUS = 13'h0075;
  localparam logic [12:0] ADDR_PATTERN_MODE_CONTROL = 13'h00C0;
  localparam logic [12:0] ADDR_PATTERN_ONE_LOW      = 13'h00C2;
  localparam logic [12:0] ADDR_PATTERN_ONE_HIGH     = 13'h00C3;
  localparam logic [12:0] ADDR_PATTERN_TWO_LOW      = 13'h00C4;
  localparam logic [12:0] ADDR_PATTERN_TWO_HIGH     = 13'h00C5;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // serial port setup and phase slip field positions
  localparam int SETUP_DRIVE_ON_BIT  = 7;
  localparam int SETUP_LSB_FIRST_BIT = 6;
  localparam int SETUP_SOFT_RST_BIT  = 5;
  localparam int SLIP_BIT            = 0;

  // ddr setup / status field positions
  localparam int DLL_SLOW_BIT   = 6;
  localparam int DDR_ENABLE_BIT = 4;
  localparam int PATT_STAT_BIT  = 0;
  localparam logic [7:0] DDR_SETUP_MASK = 8'h50;

  // three-bit select codes shared by divider, drive and coding fields
  localparam logic [2:0] SEL_PIN  = 3'h0;
  localparam logic [2:0] SEL_ONE  = 3'h1;
  localparam logic [2:0] SEL_TWO  = 3'h2;
  localparam logic [2:0] SEL_FOUR = 3'h4;

  // three-level pin levels after synchronising
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_MID  = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // pattern mode control fields
  localparam int USER_MODE_HI = 7;
  localparam int USER_MODE_LO = 6;
  localparam logic [1:0] USER_STATIC    = 2'h0;
  localparam logic [1:0] USER_ALTERNATE = 2'h1;
  localparam logic [3:0] TEST_OFF     = 4'h0;
  localparam logic [3:0] TEST_MID     = 4'h1;
  localparam logic [3:0] TEST_POS     = 4'h2;
  localparam logic [3:0] TEST_NEG     = 4'h3;
  localparam logic [3:0] TEST_CHECKER = 4'h4;
  localparam logic [3:0] TEST_ONEZERO = 4'h7;
  localparam logic [3:0] TEST_USER    = 4'h8;

  // fixed test words
  localparam logic [15:0] WORD_MIDSCALE = 16'h8000;
  localparam logic [15:0] WORD_ONES     = 16'hFFFF;
  localparam logic [15:0] WORD_ZEROS    = 16'h0000;
  localparam logic [15:0] WORD_CHECK_A  = 16'hAAAA;
  localparam logic [15:0] WORD_CHECK_B  = 16'h5555;

  // divider counter
  localparam logic [1:0] DIV_CNT_ZERO = 2'h0;
  localparam logic [1:0] DIV_CNT_ONE  = 2'h1;
  localparam logic [1:0] DIV_CNT_TWO  = 2'h2;
  localparam logic [1:0] DIV_CNT_LAST4 = 2'h3;
endpackage

// [logic/agct_divider.sv]
/*
  agct_divider: divides the input clock by one, two or four as a one-cycle
  enable pulse, and in divide-by-four slips the divided edge one input cycle earlier on request.
  Assumes ratio is a one-hot select and slip_pulse is one cycle wide.
*/
`timescale 1ns/1ps
module agct_divider
  import agct_pkg::*;
(
  input  wire logic       ref_clk,    // input clock
  input  wire logic       rstn,       // synchronous reset, active low
  input  wire logic [2:0] ratio,      // one-hot divisor select
  input  wire logic       slip_pulse, // advance the divided edge
  output logic            div_en      // divided clock rising-edge enable
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] last;

  // next count; a slip in divide-by-four skips one count
  always_comb begin
    cnt_next = DIV_CNT_ZERO;
    last     = DIV_CNT_ZERO;
    if (ratio == SEL_FOUR) begin
      last = DIV_CNT_LAST4;
    end else if (ratio == SEL_TWO) begin
      last = DIV_CNT_ONE;
    end
    if (ratio == SEL_FOUR && slip_pulse) begin
      cnt_next = cnt_reg + DIV_CNT_TWO;
    end else if (cnt_reg >= last) begin
      cnt_next = DIV_CNT_ZERO;
    end else begin
      cnt_next = cnt_reg + DIV_CNT_ONE;
    end
  end

  // count register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_reg <= DIV_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign div_en = (cnt_reg == DIV_CNT_ZERO); // divided rising edge
endmodule

// [dv/agct_regs_properties.sv]
/*
  agct_regs_properties: port-level assertions for the config and pattern bank.
  Assumes it is bound onto agct_regs: one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module agct_chk (
  input wire logic        ref_clk,             // clock
  input wire logic        rstn,                // reset, active low
  input wire logic [12:0] reg_addr,            // address
  input wire logic [7:0]  reg_wdata,           // write data
  input wire logic        reg_wr,              // write strobe
  input wire logic        reg_rd,              // read strobe
  input wire logic [7:0]  reg_rdata,           // read data
  input wire logic        reg_rvalid,          // read valid
  input wire logic [2:0]  div_ratio,           // divisor
  input wire logic        div_en,              // divided enable
  input wire logic [2:0]  out_drive,           // drive mode
  input wire logic [2:0]  out_coding,          // coding
  input wire logic        ddr_enable,          // ddr on
  input wire logic        dll_slow,            // loop range
  input wire logic        serial_out_drive_on, // serial out on
  input wire logic [7:0]  burst_end,           // burst end
  input wire logic [15:0] test_word,           // test word
  input wire logic        test_active          // pattern on
);
  // single domain, so clock and reset are shared by every property
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  chk_rdata_hold: assert property ($past(rstn) && !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_div_onehot: assert property ($onehot(div_ratio))
    else $error("divisor not one-hot");
  chk_quarter_gap: assert property ((div_ratio == 3'h4 && div_en) ##1 div_ratio == 3'h4 |-> !div_en)
    else $error("divide by four enable too close");
  chk_half_gap: assert property ((div_ratio == 3'h2 && div_en) ##1 div_ratio == 3'h2 |-> !div_en)
    else $error("divide by two enable too close");
  chk_full_rate: assert property ((div_ratio == 3'h1) [*5] |-> div_en)
    else $error("divide by one enable missing");
  chk_modes_onehot: assert property ($onehot(out_drive) && $onehot(out_coding))
    else $error("drive or coding not one-hot");
  chk_setup_write: assert property (reg_wr && reg_addr == 13'h0000 |=>
    serial_out_drive_on == ($past(reg_wdata[5]) ? 1'b0 : $past(reg_wdata[7])))
    else $error("setup write not reflected");
  chk_burst_write: assert property (reg_wr && reg_addr == 13'h0002 |=> burst_end == $past(reg_wdata))
    else $error("burst end not stored");
  chk_ddr_toggle: assert property (reg_wr && reg_addr == 13'h0074 |=>
    ddr_enable == ($past(ddr_enable) ^ $past(reg_wdata[4])))
    else $error("ddr bit did not toggle as written");
  chk_dll_toggle: assert property (reg_wr && reg_addr == 13'h0074 |=>
    dll_slow == ($past(dll_slow) ^ $past(reg_wdata[6])))
    else $error("loop range bit did not toggle as written");
  chk_idle_word: assert property (!test_active |-> test_word == 16'h0000)
    else $error("test word not zero while idle");
endmodule

bind agct_regs agct_chk u_agct_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .reg_rvalid, .div_ratio, .div_en, .out_drive, .out_coding, .ddr_enable, .dll_slow, .serial_out_drive_on,
  .burst_end, .test_word, .test_active);

// [dv/agct_host_model.sv]
/*
  agct_host_model: register bus master standing in for the serial engine.
  Assumes one-cycle strobes on ref_clk; the bench calls its tasks.
*/
`timescale 1ns/1ps
module agct_host_model (
  input  wire logic        ref_clk,    // clock
  output logic      [12:0] reg_addr,   // address
  output logic      [7:0]  reg_wdata,  // write data
  output logic             reg_wr,     // write strobe
  output logic             reg_rd,     // read strobe
  input  wire logic [7:0]  reg_rdata,  // read data
  input  wire logic        reg_rvalid  // read valid
);
  // bus idle at time zero
  initial begin
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one write; released lines show the inverse so stale values never look valid
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge ref_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask

  // one read; answer taken one edge after the strobe
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge ref_clk);
    #1 {reg_addr, reg_rd} = {~a, 1'b0};
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  // slip request is a zero then a one in the slip bit
  task automatic slip();
    wr(13'h0071, 8'h00);
    wr(13'h0071, 8'h01);
  endtask

  // ddr setup goes through read, read, xor, xor, write; caller keeps loop range to the sample rate
  task automatic set_mode_b(input logic [7:0] want);
    logic [7:0] b;
    logic [7:0] s;
    logic       v;
    rd(13'h0074, b, v);
    rd(13'h0075, s, v);
    wr(13'h0074, (b ^ s) ^ want);
  endtask
endmodule

// [dv/agct_regs_tb_top.sv]
/*
  agct_regs_tb_top: self-checking bench for the config and pattern bank.
  Assumes the host model drives the bus; select pins are driven here.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module agct_regs_tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn;
  logic [12:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, burst_end, d;
  logic        reg_wr, reg_rd, reg_rvalid, div_en, ddr_enable, dll_slow, v;
  logic        serial_out_drive_on, lsb_first, test_active;
  logic [1:0]  divider_select_pin, output_drive_select_pin, output_coding_select_pin;
  logic [2:0]  div_ratio, out_drive, out_coding, c;
  logic [15:0] test_word, uw1, uw2, a, b;
  logic [32:0] e;
  logic [31:0] seed = 32'h0000_0002;
  logic [12:0] addrs [13] = '{13'h0000, 13'h0001, 13'h0002, 13'h0071, 13'h0072, 13'h0073, 13'h0074,
                              13'h0075, 13'h00C0, 13'h00C2, 13'h00C3, 13'h00C4, 13'h00C5};
  logic [7:0]  want [4] = '{8'h50, 8'h10, 8'h40, 8'h00};
  int          n_errors = 0;
  int          n_tests = 0;
  int          gap_cnt = 0;
  int          min_gap = 99;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  agct_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);
  agct_regs DUT (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .divider_select_pin, .output_drive_select_pin, .output_coding_select_pin, .div_ratio, .div_en,
    .out_drive, .out_coding, .ddr_enable, .dll_slow, .serial_out_drive_on, .lsb_first, .burst_end,
    .test_word, .test_active);

  // shortest spacing seen between divided enables
  always @(posedge ref_clk) begin
    gap_cnt++;
    if (div_en === 1'b1) begin
      if (gap_cnt < min_gap) min_gap = gap_cnt;
      gap_cnt = 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {active, word one, word two} for a test code and user mode
  function automatic logic [32:0] exp_pat(input logic [3:0] k, input logic alt);
    case (k)
      4'h1: return {1'b1, 16'h8000, 16'h8000};
      4'h2: return {1'b1, 16'hFFFF, 16'hFFFF};
      4'h3: return {1'b1, 16'h0000, 16'h0000};
      4'h4: return {1'b1, 16'hAAAA, alt ? 16'h5555 : 16'hAAAA};
      4'h7: return {1'b1, 16'hFFFF, alt ? 16'h0000 : 16'hFFFF};
      4'h8: return {1'b1, uw1, alt ? uw2 : uw1};
      default: return 33'h0_0000_0000;
    endcase
  endfunction

  task automatic gap_after(input int exp);
    repeat (12) @(posedge ref_clk);
    #1 `CHK(min_gap, exp)
  endtask

  task automatic gap_chk(input int exp);
    repeat (6) @(posedge ref_clk);
    #1 min_gap = 99;
    gap_after(exp);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #1_000_000;
    n_errors++;
    $display("Error t=%0t watchdog expired", $time);
    summarize();
  end

  // test sequence
  initial begin
    rstn = 1'b0;
    {divider_select_pin, output_drive_select_pin, output_coding_select_pin} = 6'h00;
    repeat (5) @(posedge ref_clk);
    #1 rstn = 1'b1;
    foreach (addrs[i]) begin
      host.rd(addrs[i], d, v);
      `CHK({v, d}, 9'h100)
    end
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      for (int j = 9; j < 13; j++) begin
        c = 3'(j);
        d = 8'(rnd());
        host.wr(addrs[j], d);
        host.rd(addrs[j], e[7:0], v);
        `CHK(e[7:0], d)
      end
      d = 8'(rnd());
      host.wr(13'h0002, d);
      `CHK(burst_end, d)
      d = 8'(rnd()) & 8'hDF;
      host.wr(13'h0000, d);
      `CHK({serial_out_drive_on, lsb_first}, d[7:6])
      host.rd(13'h0000, e[7:0], v);
      `CHK(e[7:0], {d[7:6], 4'h0, d[6], d[7]})
    end
    $display("read write done");
    for (int p = 0; p < 3; p++) begin
      {divider_select_pin, output_drive_select_pin, output_coding_select_pin} = {3{2'(p)}};
      host.wr(13'h0072, 8'h00);
      host.wr(13'h0073, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 `CHK({div_ratio, out_drive, out_coding}, {3{3'(1 << p)}})
      c = 3'(1 << p);
      host.wr(13'h0072, {5'h00, c});
      host.wr(13'h0073, {c, 2'h0, c});
      {divider_select_pin, output_drive_select_pin, output_coding_select_pin} = 6'(rnd());
      gap_chk(int'(c));
      `CHK({div_ratio, out_drive, out_coding}, {c, c, c})
    end
    $display("divider and output modes done");
    min_gap = 99;
    // line up on a divided edge so the slip lands at a known count
    @(posedge ref_clk iff div_en === 1'b1);
    host.slip();
    gap_after(3);
    min_gap = 99;
    host.wr(13'h0071, 8'h01);
    gap_after(4);
    $display("phase slip done");
    host.wr(13'h0002, 8'h5A);
    host.wr(13'h0073, 8'h41);
    host.wr(13'h0000, 8'h20);
    host.rd(13'h0002, d, v);
    `CHK(d, 8'h00)
    host.rd(13'h0000, d, v);
    `CHK(d, 8'h00)
    host.rd(13'h0072, d, v);
    `CHK(d, 8'h04)
    host.rd(13'h0073, d, v);
    `CHK(d, 8'h41)
    $display("soft reset done");
    foreach (want[i]) begin
      host.set_mode_b(want[i]);
      `CHK({dll_slow, ddr_enable}, {want[i][6], want[i][4]})
      host.wr(13'h0075, 8'hFF);
      host.rd(13'h0075, d, v);
      `CHK(d, {1'b0, want[i][6], 1'b0, want[i][4], 4'h0})
    end
    $display("ddr setup done");
    host.wr(13'h0072, 8'h01);
    uw1 = 16'(rnd());
    uw2 = 16'(rnd());
    host.wr(13'h00C2, uw1[7:0]);
    host.wr(13'h00C3, uw1[15:8]);
    host.wr(13'h00C4, uw2[7:0]);
    host.wr(13'h00C5, uw2[15:8]);
    // every code and every user mode; reserved codes stay off, reserved modes act static
    for (int k = 0; k < 16; k++) begin
      for (int m = 0; m < 4; m++) begin
        host.wr(13'h00C0, {m[1:0], 2'h0, k[3:0]});
        e = exp_pat(k[3:0], m == 1);
        repeat (8) @(posedge ref_clk);
        #1 a = test_word;
        @(posedge ref_clk);
        #1 b = test_word;
        `CHK(test_active, e[32])
        `CHK((a === e[31:16] && b === e[15:0]) || (a === e[15:0] && b === e[31:16]), 1'b1)
      end
    end
    $display("test patterns done");
    summarize();
  end
endmodule
